// [rtl/boot_diag_pkg.sv]
// Package: register map, field positions, reset values and loader event carrier
package boot_diag_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [17:0] CFG_VIEW_OFS = 18'h1D3B0;
  localparam logic [17:0] PROG_VIEW_OFS = 18'h1D3B8;

  // ----------------------------------------------------------------
  // Field positions (bit 0 of the map is the word's LSB)
  // ----------------------------------------------------------------
  localparam int PAIRS_MSB = 31;
  localparam int PAIRS_LSB = 16;
  localparam int BADDR_MSB = 15;
  localparam int BADDR_LSB = 0;
  localparam int IN_PROGRESS_BIT = 31;
  localparam int DISABLED_BIT = 30;
  localparam int TWO_BYTE_BIT = 29;
  localparam int PAGE_STEP_BIT = 28;
  localparam int DEV_ADDR_MSB = 6;
  localparam int DEV_ADDR_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [15:0] PAIRS_RST = 16'h0000;
  localparam logic [15:0] BADDR_RST = 16'h0000;
  localparam logic [6:0] DEV_ADDR_RST = 7'h00;
  localparam logic [15:0] CHAIN_ALIGN_MASK = 16'hFFF8;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Events and levels from the boot loader, all on CLK
  typedef struct packed {
    logic count_load;        // first two bytes of an EEPROM are in
    logic [7:0] count_hi;    // first byte fetched
    logic [7:0] count_lo;    // second byte fetched
    logic pair_done;         // one address/data pair fetched
    logic byte_ok;           // one byte read from the EEPROM
    logic chain;             // chain operation: new EEPROM selected
    logic [15:0] chain_addr; // address value of the boot control register
    logic in_progress;
    logic disabled;
    logic two_byte;
    logic page_step_en;
    logic dev_addr_load;
    logic [6:0] dev_addr;
    logic page_step;         // page boundary crossed
  } loader_evt_t;

endpackage

// [rtl/boot_progress_track.sv]
// Pair counter and peripheral byte address tracker
`timescale 1ns/1ns
`default_nettype none
module boot_progress_track (
  input wire logic clk,
  input wire logic rst_n,
  input wire boot_diag_pkg::loader_evt_t evt,
  output logic [15:0] pairs_remaining_q,
  output logic [15:0] byte_addr_q
);

  logic [15:0] pairs_remaining_d;
  logic [15:0] byte_addr_d;

  always_comb begin
    pairs_remaining_d = pairs_remaining_q;
    if (evt.count_load) begin
      pairs_remaining_d = {evt.count_hi, evt.count_lo};
    end else if (evt.pair_done && pairs_remaining_q != 16'h0000) begin
      pairs_remaining_d = pairs_remaining_q - 16'h0001;
    end
  end

  always_comb begin
    byte_addr_d = byte_addr_q;
    // A chain realigns the address, so it wins over a byte in the same cycle
    if (evt.chain) begin
      byte_addr_d = evt.chain_addr & boot_diag_pkg::CHAIN_ALIGN_MASK;
    end else if (evt.byte_ok) begin
      byte_addr_d = byte_addr_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pairs_remaining_q <= boot_diag_pkg::PAIRS_RST;
      byte_addr_q <= boot_diag_pkg::BADDR_RST;
    end else begin
      pairs_remaining_q <= pairs_remaining_d;
      byte_addr_q <= byte_addr_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pair_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt.count_load |=> pairs_remaining_q == {$past(evt.count_hi), $past(evt.count_lo)})
    else $error("pair counter not loaded from first two bytes");

  pair_decrement_a: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.pair_done && !evt.count_load && pairs_remaining_q != 16'h0000)
    |=> pairs_remaining_q == $past(pairs_remaining_q) - 16'h0001)
    else $error("pair counter did not count down by one");

  chain_align_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt.chain |=> byte_addr_q == {$past(evt.chain_addr[15:3]), 3'h0})
    else $error("byte address not loaded aligned on chain");

  byte_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.byte_ok && !evt.chain) |=> byte_addr_q == $past(byte_addr_q) + 16'h0001)
    else $error("byte address did not advance by one");

endmodule
`default_nettype wire

// [rtl/boot_diag_status.sv]
// Boot loader diagnostic status views behind an Avalon-MM slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module boot_diag_status (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [17:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire boot_diag_pkg::loader_evt_t LOADER
);

  // ----------------------------------------------------------------
  // Progress tracking
  // ----------------------------------------------------------------
  logic [15:0] pairs_remaining;
  logic [15:0] byte_addr;

  boot_progress_track u_track (
    .clk(CLK),
    .rst_n(RST_N),
    .evt(LOADER),
    .pairs_remaining_q(pairs_remaining),
    .byte_addr_q(byte_addr)
  );

  // ----------------------------------------------------------------
  // Configuration view state
  // ----------------------------------------------------------------
  logic load_in_progress_q, load_in_progress_d;
  logic load_disabled_q, load_disabled_d;
  logic eeprom_addr_two_byte_q, eeprom_addr_two_byte_d;
  logic page_step_enable_q, page_step_enable_d;
  logic [6:0] dev_addr_q, dev_addr_d;

  always_comb begin
    load_in_progress_d = LOADER.in_progress;
    load_disabled_d = LOADER.disabled;
    // A disabled load has no EEPROM, so the size reads as one byte
    eeprom_addr_two_byte_d = LOADER.two_byte && !LOADER.disabled;
    page_step_enable_d = LOADER.page_step_en;
    dev_addr_d = dev_addr_q;
    if (LOADER.dev_addr_load) begin
      dev_addr_d = LOADER.dev_addr;
    end else if (LOADER.page_step && LOADER.page_step_en) begin
      dev_addr_d = dev_addr_q + 7'h01;
    end
  end

  // Disable and size have no defined reset value; they are cleared anyway
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      load_in_progress_q <= 1'b0;
      load_disabled_q <= 1'b0;
      eeprom_addr_two_byte_q <= 1'b0;
      page_step_enable_q <= 1'b0;
      dev_addr_q <= boot_diag_pkg::DEV_ADDR_RST;
    end else begin
      load_in_progress_q <= load_in_progress_d;
      load_disabled_q <= load_disabled_d;
      eeprom_addr_two_byte_q <= eeprom_addr_two_byte_d;
      page_step_enable_q <= page_step_enable_d;
      dev_addr_q <= dev_addr_d;
    end
  end

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_mux(input logic [17:0] addr,
                                           input logic [31:0] cfg,
                                           input logic [31:0] prog);
    read_mux = boot_diag_pkg::UNMAPPED_DATA;
    if (addr == boot_diag_pkg::CFG_VIEW_OFS) begin
      read_mux = cfg;
    end else if (addr == boot_diag_pkg::PROG_VIEW_OFS) begin
      read_mux = prog;
    end
  endfunction

  logic [31:0] cfg_word;
  logic [31:0] prog_word;

  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[boot_diag_pkg::IN_PROGRESS_BIT] = load_in_progress_q;
    cfg_word[boot_diag_pkg::DISABLED_BIT] = load_disabled_q;
    cfg_word[boot_diag_pkg::TWO_BYTE_BIT] = eeprom_addr_two_byte_q;
    cfg_word[boot_diag_pkg::PAGE_STEP_BIT] = page_step_enable_q;
    cfg_word[boot_diag_pkg::DEV_ADDR_MSB:boot_diag_pkg::DEV_ADDR_LSB] = dev_addr_q;
    prog_word = 32'h0000_0000;
    prog_word[boot_diag_pkg::PAIRS_MSB:boot_diag_pkg::PAIRS_LSB] = pairs_remaining;
    prog_word[boot_diag_pkg::BADDR_MSB:boot_diag_pkg::BADDR_LSB] = byte_addr;
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Every access waits one cycle so that read data come from a flop.
  // Writes are answered but change nothing: both views are read only.
  logic ack_q, ack_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] unused_wdata;

  always_comb begin
    unused_wdata = WRITEDATA;
    ack_d = (READ || WRITE) && !ack_q;
    wait_d = !ack_d;
    rdata_d = rdata_q;
    if (ack_d && READ) begin
      rdata_d = read_mux(ADDRESS, cfg_word, prog_word);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign READDATA = rdata_q;
  assign WAITREQUEST = wait_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  progress_view_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (READ && !ack_q && ADDRESS == boot_diag_pkg::PROG_VIEW_OFS)
    |=> !WAITREQUEST && READDATA == {$past(pairs_remaining), $past(byte_addr)})
    else $error("progress view read data wrong");

  access_answer_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("access not answered in one cycle");

  // Read data are launched at the edge that takes the request, so they are
  // compared with the views as they stood at that edge
  cfg_view_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (READ && !ack_q && ADDRESS == boot_diag_pkg::CFG_VIEW_OFS)
    |=> READDATA == {$past(load_in_progress_q), $past(load_disabled_q), $past(eeprom_addr_two_byte_q),
                     $past(page_step_enable_q), 21'h000000, $past(dev_addr_q)})
    else $error("config view read data wrong");

  unmapped_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (READ && !ack_q && ADDRESS != boot_diag_pkg::CFG_VIEW_OFS && ADDRESS != boot_diag_pkg::PROG_VIEW_OFS)
    |=> READDATA == boot_diag_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");

  read_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !(READ && !ack_q) |=> $stable(READDATA))
    else $error("read data changed without a read");

  idle_wait_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!READ && !WRITE) |=> WAITREQUEST)
    else $error("wait released without a request");

  answer_once_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !WAITREQUEST |=> WAITREQUEST)
    else $error("wait released for more than one cycle");

  in_progress_view_a: assert property (@(posedge CLK) disable iff (!RST_N)
    LOADER.in_progress |=> load_in_progress_q)
    else $error("load in progress not shown");

  disabled_view_a: assert property (@(posedge CLK) disable iff (!RST_N)
    load_disabled_q == $past(LOADER.disabled))
    else $error("load disabled not shown");

  size_forced_a: assert property (@(posedge CLK) disable iff (!RST_N)
    load_disabled_q |-> !eeprom_addr_two_byte_q)
    else $error("two-byte size shown while disabled");

  page_step_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (LOADER.page_step && LOADER.page_step_en && !LOADER.dev_addr_load)
    |=> dev_addr_q == $past(dev_addr_q) + 7'h01)
    else $error("device address did not step");

  no_step_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!LOADER.page_step_en && !LOADER.dev_addr_load) |=> $stable(dev_addr_q))
    else $error("device address moved without page step");

  dev_addr_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (LOADER.page_step_en && !LOADER.page_step && !LOADER.dev_addr_load) |=> $stable(dev_addr_q))
    else $error("device address moved between page steps");

  dev_addr_load_a: assert property (@(posedge CLK) disable iff (!RST_N)
    LOADER.dev_addr_load |=> dev_addr_q == $past(LOADER.dev_addr))
    else $error("device address not loaded");

  page_enable_view_a: assert property (@(posedge CLK) disable iff (!RST_N)
    page_step_enable_q == $past(LOADER.page_step_en))
    else $error("page step enable not shown");

  size_shown_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (LOADER.two_byte && !LOADER.disabled) |=> eeprom_addr_two_byte_q)
    else $error("two-byte size not shown");

  size_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !LOADER.two_byte |=> !eeprom_addr_two_byte_q)
    else $error("two-byte size shown without request");

  // Views lag the loader by one edge; a level already high as reset lifts shows a cycle late
  idle_view_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !LOADER.in_progress |=> !load_in_progress_q)
    else $error("load in progress shown while idle");

endmodule
`default_nettype wire

// [verification/eeprom_boot_model.sv]
// Far-side model: serial EEPROM image streamed to the loader as byte events
`timescale 1ns/1ns
`default_nettype none
module eeprom_boot_model #(
  parameter logic [63:0] IMAGE = 64'h0003_1122_3344_5566
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic restart,
  input wire boot_diag_pkg::loader_evt_t ctl,
  output var boot_diag_pkg::loader_evt_t evt
);
  // ----------------------------------------------------------------
  // Byte stream: two count bytes, then address/data pairs of two bytes
  // ----------------------------------------------------------------
  localparam int N = 8;
  logic [3:0] idx_q;
  logic ok_q;
  logic cnt_q;
  logic pair_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 4'h0;
      ok_q <= 1'b0;
      cnt_q <= 1'b0;
      pair_q <= 1'b0;
    end else begin
      ok_q <= step && idx_q < N;
      cnt_q <= step && idx_q == 4'h1;
      pair_q <= step && idx_q > 4'h2 && idx_q < N && idx_q[0];
      if (restart) begin
        idx_q <= 4'h0;
      end else if (step && idx_q < N) begin
        idx_q <= idx_q + 4'h1;
      end
    end
  end
  // Stream pulses, count bytes and in_progress override the bench's own control fields
  always_comb begin
    evt = ctl;
    evt.byte_ok = ok_q;
    evt.count_load = cnt_q;
    evt.count_hi = IMAGE[63:56];
    evt.count_lo = IMAGE[55:48];
    evt.pair_done = pair_q;
    evt.in_progress = idx_q != 4'h0 && idx_q < N;
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Testbench: register reads over Avalon-MM while the EEPROM model feeds the loader
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [17:0] ADDRESS = 18'h00000;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0000_0000;
  logic [31:0] READDATA;
  logic WAITREQUEST;
  logic step = 1'b0;
  logic restart = 1'b0;
  boot_diag_pkg::loader_evt_t ctl = '0;
  boot_diag_pkg::loader_evt_t evt;
  logic [31:0] rd;
  int n_mismatch = 0;
  int n_compared = 0;
  localparam logic [17:0] CFG = boot_diag_pkg::CFG_VIEW_OFS;
  localparam logic [17:0] PRG = boot_diag_pkg::PROG_VIEW_OFS;

  initial forever #5 CLK = ~CLK;

  eeprom_boot_model eeprom_boot_model_inst (.clk(CLK), .rst_n(RST_N), .step(step), .restart(restart),
    .ctl(ctl), .evt(evt));
  boot_diag_status boot_diag_status_inst (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .LOADER(evt));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [17:0] a, output logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    ADDRESS <= a;
    READ <= !wr;
    WRITE <= wr;
    WRITEDATA <= 32'hFFFF_FFFF;
    do begin
      @(posedge CLK);
      k++;
    end while (WAITREQUEST !== 1'b0 && k < 40);
    d = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    if (k >= 40) begin
      n_mismatch++;
      $display("[ERR] %0t bus request not answered", $time);
      print_verdict();
    end
  endtask
  task automatic steps(input int n);
    @(posedge CLK);
    step <= 1'b1;
    repeat (n) @(posedge CLK);
    step <= 1'b0;
  endtask
  function automatic logic [31:0] cfgw(input logic b, dis, two, pg, input logic [6:0] dev);
    cfgw = {b, dis, two & !dis, pg, 21'h0, dev};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    bus(1'b0, PRG, rd); chk(rd, 32'h0000_0000);
    bus(1'b0, CFG, rd); chk(rd, 32'h0000_0000);
    bus(1'b1, PRG, rd);
    bus(1'b1, CFG, rd);
    bus(1'b0, PRG, rd); chk(rd, 32'h0000_0000);
    bus(1'b0, 18'h00004, rd); chk(rd, boot_diag_pkg::UNMAPPED_DATA);
    $display("test reset_and_writes done");
    steps(2);
    bus(1'b0, PRG, rd); chk(rd, 32'h0003_0002);
    bus(1'b0, CFG, rd); chk(rd, cfgw(1'b1, 1'b0, 1'b0, 1'b0, 7'h00));
    steps(7);
    bus(1'b0, PRG, rd); chk(rd, 32'h0000_0008);
    bus(1'b0, CFG, rd); chk(rd, cfgw(1'b0, 1'b0, 1'b0, 1'b0, 7'h00));
    $display("test load_stream done");
    @(posedge CLK);
    ctl.disabled <= 1'b1;
    ctl.two_byte <= 1'b1;
    ctl.page_step_en <= 1'b1;
    ctl.dev_addr_load <= 1'b1;
    ctl.dev_addr <= 7'h12;
    @(posedge CLK);
    ctl.dev_addr_load <= 1'b0;
    ctl.page_step <= 1'b1;
    @(posedge CLK);
    ctl.page_step <= 1'b0;
    bus(1'b0, CFG, rd); chk(rd, cfgw(1'b0, 1'b1, 1'b1, 1'b1, 7'h13));
    ctl.disabled <= 1'b0;
    ctl.page_step_en <= 1'b0;
    @(posedge CLK);
    ctl.page_step <= 1'b1;
    @(posedge CLK);
    ctl.page_step <= 1'b0;
    bus(1'b0, CFG, rd); chk(rd, cfgw(1'b0, 1'b0, 1'b1, 1'b0, 7'h13));
    $display("test config_view done");
    @(posedge CLK);
    ctl.chain <= 1'b1;
    ctl.chain_addr <= 16'hABCF;
    restart <= 1'b1;
    @(posedge CLK);
    ctl.chain <= 1'b0;
    restart <= 1'b0;
    bus(1'b0, PRG, rd); chk(rd, 32'h0000_ABC8);
    steps(2);
    bus(1'b0, PRG, rd); chk(rd, 32'h0003_ABCA);
    $display("test chain done");
    @(posedge CLK);
    RST_N <= 1'b0;
    ctl <= '0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    bus(1'b0, PRG, rd); chk(rd, 32'h0000_0000);
    bus(1'b0, CFG, rd); chk(rd, 32'h0000_0000);
    $display("test mid_reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
